//--- core/aex_regs.svh
// Register offsets, field positions, encodings and reset values of the execute block
`ifndef AEX_REGS_SVH
`define AEX_REGS_SVH

`define AEX_OFF_INSTR 8'h00
`define AEX_OFF_ACC 8'h04
`define AEX_OFF_STATUS 8'h08
`define AEX_OFF_FADDR 8'h0C
`define AEX_OFF_FDATA 8'h10
`define AEX_OFF_CYCLES 8'h14

`define AEX_STAT_CARRY 0
`define AEX_STAT_HALF 1
`define AEX_STAT_ZERO 2
`define AEX_STAT_SKIP 3
`define AEX_STAT_BUSY 4

`define AEX_OP_NOP 4'h0
`define AEX_OP_ADD_LIT 4'h1
`define AEX_OP_ADD_REG 4'h2
`define AEX_OP_AND_LIT 4'h3
`define AEX_OP_AND_REG 4'h4
`define AEX_OP_BIT_CLR 4'h5
`define AEX_OP_BIT_SET 4'h6
`define AEX_OP_SKIP_SET 4'h7
`define AEX_OP_SKIP_CLR 4'h8

`define AEX_ACC_RST 8'h00
`define AEX_FADDR_RST 7'h00
`define AEX_CYC_RST 32'h0000_0000
`define AEX_RESP_OKAY 2'h0
`define AEX_RESP_SLVERR 2'h2

`endif

//--- core/aex_pkg.sv
// Types shared by the execute block
package aex_pkg;

   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_EXEC} aex_state_t;

   typedef struct packed {
      logic [7:0] pad_hi;
      logic [7:0] literal;
      logic pad_mid;
      logic [6:0] faddr;
      logic [2:0] bsel;
      logic dest;
      logic [3:0] op;
   } aex_instr_t;

   typedef struct packed {
      logic zero;
      logic half_carry_flag;
      logic carry;
   } aex_flags_t;

endpackage : aex_pkg

//--- core/aex_file_mem.sv
// File register store, 128 bytes, one port, registered read data
`timescale 1ns/100ps
module aex_file_mem (
   input wire logic clk_i,          // Core clock
   input wire logic [6:0] addr_i,   // Byte address
   input wire logic we_i,           // Write strobe
   input wire logic [7:0] wdata_i,  // Write data
   output logic [7:0] rdata_o       // Data of last cycle's address
);
   logic [7:0] mem_q [128];

   // Read before write; no reset so it maps to plain RAM
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem_q[addr_i] <= wdata_i;
      end
      rdata_o <= mem_q[addr_i];
   end

endmodule : aex_file_mem

//--- core/aex_core.sv
// Add, AND, bit and skip execute unit with an AXI4-Lite register slave
//
// Overview of operation
// - Literal add puts accumulator plus literal in the accumulator and updates all flags.
// - Register add sums accumulator and file register (7-bit address) and updates all flags.
// - For register add and AND, dest 0 writes the accumulator and dest 1 the file register.
// - Bit clear forces the chosen bit 0..7 of the file register to zero, flags untouched.
// - Bit set forces the chosen bit of the file register to one, flags untouched.
// - Literal AND puts accumulator AND literal in the accumulator and updates only Z.
// - Register AND routes accumulator AND file register by dest and updates only Z.
// - Skip-if-set with the bit at one turns the next instruction into a no-op, two cycles.
// - Skip-if-set with the bit at zero lets the next instruction run normally.
// - Skip-if-clear with the bit at zero turns the next instruction into a no-op, two cycles.
// - Skip-if-clear with the bit at one lets the next run; neither test touches a flag.
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "aex_regs.svh"
module aex_core (
   input wire logic clk_i,                // 125 MHz core clock
   input wire logic sys_rst_i,            // Async reset, active high
   input wire logic [7:0] s_axi_awaddr,   // Write address
   input wire logic s_axi_awvalid,        // Write address valid
   output logic s_axi_awready,            // Write address ready
   input wire logic [31:0] s_axi_wdata,   // Write data
   input wire logic [3:0] s_axi_wstrb,    // Write byte strobes
   input wire logic s_axi_wvalid,         // Write data valid
   output logic s_axi_wready,             // Write data ready
   output logic [1:0] s_axi_bresp,        // Write response
   output logic s_axi_bvalid,             // Write response valid
   input wire logic s_axi_bready,         // Write response ready
   input wire logic [7:0] s_axi_araddr,   // Read address
   input wire logic s_axi_arvalid,        // Read address valid
   output logic s_axi_arready,            // Read address ready
   output logic [31:0] s_axi_rdata,       // Read data
   output logic [1:0] s_axi_rresp,        // Read response
   output logic s_axi_rvalid,             // Read data valid
   input wire logic s_axi_rready          // Read data ready
);
   aex_pkg::aex_state_t state_q;
   aex_pkg::aex_instr_t ins_q;
   aex_pkg::aex_instr_t ins_d;
   aex_pkg::aex_flags_t flg_q;
   logic [7:0] acc_q;
   logic skip_q;
   logic [6:0] faddr_q;
   logic [31:0] cyc_q;

   logic aw_full_q, w_full_q, rd_pend_q;
   logic [7:0] awaddr_q, araddr_q;
   logic [31:0] wdata_q, wmask;
   logic [3:0] wstrb_q;
   logic wr_go, wr_mapped, rd_mapped, issue;

   logic [6:0] mem_addr;
   logic mem_we;
   logic [7:0] mem_wdata, mem_rdata;

   logic ex;
   logic [7:0] operand, res, bit_mask;
   logic [8:0] sum9;
   logic [4:0] half5;
   logic to_acc, to_mem, upd_cdc, upd_z, test_bit, skip_hit;
   logic [31:0] rd_val;

   // AXI write side: address and data latch independently
   assign s_axi_awready = !aw_full_q;
   assign s_axi_wready = !w_full_q;
   assign s_axi_arready = (state_q == aex_pkg::ST_IDLE) && !rd_pend_q && !s_axi_rvalid && !wr_go;
   // Register writes wait for idle so software never races the datapath
   assign wr_go = aw_full_q && w_full_q && !s_axi_bvalid && (state_q == aex_pkg::ST_IDLE);
   assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   assign ins_d = aex_pkg::aex_instr_t'(wdata_q & wmask);
   assign issue = wr_go && (awaddr_q == `AEX_OFF_INSTR);

   always_comb begin
      unique case (awaddr_q)
         `AEX_OFF_INSTR, `AEX_OFF_ACC, `AEX_OFF_STATUS, `AEX_OFF_FADDR, `AEX_OFF_FDATA,
         `AEX_OFF_CYCLES: wr_mapped = 1'b1;
         default: wr_mapped = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `AEX_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q <= 1'b1;
            awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
         end else if (wr_go) begin
            aw_full_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end else if (wr_go) begin
            w_full_q <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? `AEX_RESP_OKAY : `AEX_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Datapath: operand comes from the literal or the file register just read
   assign ex = (state_q == aex_pkg::ST_EXEC);
   assign operand = (ins_q.op == `AEX_OP_ADD_LIT || ins_q.op == `AEX_OP_AND_LIT) ?
                    ins_q.literal : mem_rdata;
   assign sum9 = {1'b0, acc_q} + {1'b0, operand};
   assign half5 = {1'b0, acc_q[3:0]} + {1'b0, operand[3:0]};
   assign bit_mask = 8'h01 << ins_q.bsel;
   assign test_bit = mem_rdata[ins_q.bsel];

   always_comb begin
      res = 8'h00;
      to_acc = 1'b0;
      to_mem = 1'b0;
      upd_cdc = 1'b0;
      upd_z = 1'b0;
      skip_hit = 1'b0;
      unique case (ins_q.op)
         `AEX_OP_ADD_LIT: begin
            res = sum9[7:0];
            to_acc = 1'b1;
            upd_cdc = 1'b1;
            upd_z = 1'b1;
         end
         `AEX_OP_ADD_REG: begin
            res = sum9[7:0];
            to_acc = !ins_q.dest;
            to_mem = ins_q.dest;
            upd_cdc = 1'b1;
            upd_z = 1'b1;
         end
         `AEX_OP_AND_LIT: begin
            res = acc_q & operand;
            to_acc = 1'b1;
            upd_z = 1'b1;
         end
         `AEX_OP_AND_REG: begin
            res = acc_q & operand;
            to_acc = !ins_q.dest;
            to_mem = ins_q.dest;
            upd_z = 1'b1;
         end
         `AEX_OP_BIT_CLR: begin
            res = mem_rdata & ~bit_mask;
            to_mem = 1'b1;
         end
         `AEX_OP_BIT_SET: begin
            res = mem_rdata | bit_mask;
            to_mem = 1'b1;
         end
         `AEX_OP_SKIP_SET: skip_hit = test_bit;
         `AEX_OP_SKIP_CLR: skip_hit = !test_bit;
         default: res = 8'h00;
      endcase
   end

   // File register port: datapath owns it while busy, software otherwise
   assign mem_addr = (state_q == aex_pkg::ST_IDLE) ? faddr_q : ins_q.faddr;
   assign mem_we = ex ? to_mem : (wr_go && awaddr_q == `AEX_OFF_FDATA && wstrb_q[0]);
   assign mem_wdata = ex ? res : wdata_q[7:0];

   aex_file_mem u_mem (
      .clk_i(clk_i),
      .addr_i(mem_addr),
      .we_i(mem_we),
      .wdata_i(mem_wdata),
      .rdata_o(mem_rdata)
   );

   // Sequencer; a pending skip swallows the next issued instruction as a no-op
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_q <= aex_pkg::ST_IDLE;
         ins_q <= '0;
         skip_q <= 1'b0;
         cyc_q <= `AEX_CYC_RST;
      end else begin
         unique case (state_q)
            aex_pkg::ST_IDLE: begin
               if (issue) begin
                  if (skip_q || ins_d.op == `AEX_OP_NOP || ins_d.op > `AEX_OP_SKIP_CLR) begin
                     skip_q <= 1'b0;
                     cyc_q <= cyc_q + 32'h0000_0001;
                  end else begin
                     ins_q <= ins_d;
                     state_q <= aex_pkg::ST_READ;
                  end
               end
            end
            aex_pkg::ST_READ: state_q <= aex_pkg::ST_EXEC;
            aex_pkg::ST_EXEC: begin
               skip_q <= skip_hit;
               cyc_q <= cyc_q + 32'h0000_0001;
               state_q <= aex_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         acc_q <= `AEX_ACC_RST;
         flg_q <= '0;
         faddr_q <= `AEX_FADDR_RST;
      end else begin
         if (ex) begin
            if (to_acc) begin
               acc_q <= res;
            end
            if (upd_cdc) begin
               flg_q.carry <= sum9[8];
               flg_q.half_carry_flag <= half5[4];
            end
            if (upd_z) begin
               flg_q.zero <= (res == 8'h00);
            end
         end else if (wr_go && wstrb_q[0]) begin
            if (awaddr_q == `AEX_OFF_ACC) begin
               acc_q <= wdata_q[7:0];
            end
            if (awaddr_q == `AEX_OFF_STATUS) begin
               flg_q <= aex_pkg::aex_flags_t'(wdata_q[`AEX_STAT_ZERO:`AEX_STAT_CARRY]);
            end
            if (awaddr_q == `AEX_OFF_FADDR) begin
               faddr_q <= wdata_q[6:0];
            end
         end
      end
   end

   // AXI read side: one cycle to fetch file data, answer the next
   always_comb begin
      rd_mapped = 1'b1;
      rd_val = 32'h0000_0000;
      unique case (araddr_q)
         `AEX_OFF_INSTR: rd_val = ins_q;
         `AEX_OFF_ACC: rd_val = {24'h00_0000, acc_q};
         `AEX_OFF_STATUS: begin
            rd_val[`AEX_STAT_ZERO:`AEX_STAT_CARRY] = flg_q;
            rd_val[`AEX_STAT_SKIP] = skip_q;
            rd_val[`AEX_STAT_BUSY] = (state_q != aex_pkg::ST_IDLE);
         end
         `AEX_OFF_FADDR: rd_val = {25'h000_0000, faddr_q};
         `AEX_OFF_FDATA: rd_val = {24'h00_0000, mem_rdata};
         `AEX_OFF_CYCLES: rd_val = cyc_q;
         default: rd_mapped = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rd_pend_q <= 1'b0;
         araddr_q <= 8'h00;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `AEX_RESP_OKAY;
      end else begin
         rd_pend_q <= s_axi_arvalid && s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            araddr_q <= {s_axi_araddr[7:2], 2'b00};
         end
         if (rd_pend_q) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_mapped ? `AEX_RESP_OKAY : `AEX_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);

   sequence s_test_set_hit;
      ex && ins_q.op == `AEX_OP_SKIP_SET && test_bit;
   endsequence
   sequence s_swallow;
      skip_q && issue ##1 !skip_q && state_q == aex_pkg::ST_IDLE && $stable(acc_q);
   endsequence

   chk_add_lit_acc: assert property (ex && ins_q.op == `AEX_OP_ADD_LIT |=>
      {flg_q.carry, acc_q} == ({1'b0, $past(acc_q)} + {1'b0, $past(ins_q.literal)}))
      else $error("literal add result wrong");
   chk_add_reg_flags: assert property (ex && ins_q.op == `AEX_OP_ADD_REG |=>
      flg_q.carry == (({1'b0, $past(acc_q)} + {1'b0, $past(mem_rdata)}) > 9'h0ff) &&
      flg_q.zero == (8'($past(acc_q) + $past(mem_rdata)) == 8'h00))
      else $error("register add flags wrong");
   chk_dest_file: assert property (ex && ins_q.op == `AEX_OP_AND_REG && ins_q.dest |->
      mem_we && mem_wdata == (acc_q & mem_rdata) ##1 $stable(acc_q))
      else $error("dest 1 did not go to file register");
   chk_bit_clear: assert property (ex && ins_q.op == `AEX_OP_BIT_CLR |->
      mem_we && !mem_wdata[ins_q.bsel] ##1 $stable(flg_q))
      else $error("bit clear wrong");
   chk_bit_set: assert property (ex && ins_q.op == `AEX_OP_BIT_SET |->
      mem_we && mem_wdata == (mem_rdata | bit_mask) ##1 $stable(flg_q))
      else $error("bit set wrong");
   chk_and_lit: assert property (ex && ins_q.op == `AEX_OP_AND_LIT |=>
      acc_q == ($past(acc_q) & $past(ins_q.literal)) && $stable(flg_q.carry) &&
      $stable(flg_q.half_carry_flag))
      else $error("literal AND wrong");
   chk_and_reg_zero: assert property (ex && ins_q.op == `AEX_OP_AND_REG && !ins_q.dest
      |=> flg_q.zero == (acc_q == 8'h00) && $stable(flg_q.carry))
      else $error("register AND zero flag wrong");
   chk_skip_set_arm: assert property (s_test_set_hit |=> skip_q ##0 $stable(flg_q))
      else $error("skip-if-set did not arm");
   chk_skip_nop: assert property (skip_q && issue |-> s_swallow)
      else $error("skipped instruction was not a no-op");
   chk_skip_set_pass: assert property (
      ex && ins_q.op == `AEX_OP_SKIP_SET && !test_bit |=> !skip_q)
      else $error("skip-if-set skipped on zero");
   chk_skip_clr_arm: assert property (
      ex && ins_q.op == `AEX_OP_SKIP_CLR && !test_bit |=> skip_q && cyc_q == $past(cyc_q) + 1)
      else $error("skip-if-clear did not arm");
   chk_skip_clr_pass: assert property (
      ex && ins_q.op == `AEX_OP_SKIP_CLR && test_bit |=> !skip_q && $stable(flg_q))
      else $error("skip-if-clear wrong on one");
   chk_half_carry: assert property (ex && ins_q.op == `AEX_OP_ADD_REG |=>
      flg_q.half_carry_flag == ((($past(acc_q) & 8'h0f) + ($past(mem_rdata) & 8'h0f)) > 8'h0f))
      else $error("half carry wrong");

endmodule : aex_core

//--- tb/tb_add_and_bit_ops_exec.sv
// Self-checking bench for the add, AND, bit and skip execute unit
`timescale 1ns/100ps
`include "aex_regs.svh"
module tb_add_and_bit_ops_exec;
   typedef struct packed {
      logic [3:0] op;
      logic dest;
      logic [2:0] bsel;
      logic [6:0] fa;
      logic [7:0] lit;
      logic [7:0] acc0;
      logic [7:0] f0;
      logic [2:0] fl0;
      logic [7:0] acc_e;
      logic [7:0] f_e;
      logic [2:0] fl_e;
      logic skip_e;
   } aex_row_t;

   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [7:0] s_axi_araddr = 8'h00;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   int num_errors = 0;
   int n_checks = 0;
   logic [31:0] rdat;
   logic [1:0] rrsp;
   logic [1:0] brsp;
   logic [31:0] cyc0;
   aex_row_t r;
   // Flags are {zero, half carry, carry}; in the add and AND rows seeds differ from results so stale flags show
   aex_row_t rows [0:18] = '{
      '{4'h1, 1'b0, 3'h0, 7'h05, 8'h01, 8'h0f, 8'h33, 3'h5, 8'h10, 8'h33, 3'h2, 1'b0},
      '{4'h1, 1'b0, 3'h0, 7'h05, 8'h01, 8'hff, 8'h33, 3'h0, 8'h00, 8'h33, 3'h7, 1'b0},
      '{4'h1, 1'b0, 3'h0, 7'h05, 8'h80, 8'h80, 8'h33, 3'h0, 8'h00, 8'h33, 3'h5, 1'b0},
      '{4'h1, 1'b0, 3'h0, 7'h05, 8'hff, 8'h00, 8'h33, 3'h7, 8'hff, 8'h33, 3'h0, 1'b0},
      '{4'h2, 1'b0, 3'h0, 7'h7f, 8'h00, 8'h28, 8'h19, 3'h0, 8'h41, 8'h19, 3'h2, 1'b0},
      '{4'h2, 1'b1, 3'h0, 7'h00, 8'h00, 8'hf0, 8'h20, 3'h0, 8'hf0, 8'h10, 3'h1, 1'b0},
      '{4'h3, 1'b0, 3'h0, 7'h05, 8'h0f, 8'hf0, 8'h33, 3'h3, 8'h00, 8'h33, 3'h7, 1'b0},
      '{4'h3, 1'b0, 3'h0, 7'h05, 8'ha5, 8'hff, 8'h33, 3'h5, 8'ha5, 8'h33, 3'h1, 1'b0},
      '{4'h4, 1'b0, 3'h0, 7'h40, 8'h00, 8'h3c, 8'h0f, 3'h6, 8'h0c, 8'h0f, 3'h2, 1'b0},
      '{4'h4, 1'b1, 3'h0, 7'h40, 8'h00, 8'h55, 8'haa, 3'h1, 8'h55, 8'h00, 3'h5, 1'b0},
      '{4'h5, 1'b0, 3'h7, 7'h7f, 8'h00, 8'h11, 8'hff, 3'h5, 8'h11, 8'h7f, 3'h5, 1'b0},
      '{4'h5, 1'b0, 3'h0, 7'h01, 8'h00, 8'h00, 8'h01, 3'h2, 8'h00, 8'h00, 3'h2, 1'b0},
      '{4'h6, 1'b0, 3'h0, 7'h02, 8'h00, 8'h22, 8'h00, 3'h0, 8'h22, 8'h01, 3'h0, 1'b0},
      '{4'h6, 1'b0, 3'h7, 7'h02, 8'h00, 8'h22, 8'h00, 3'h7, 8'h22, 8'h80, 3'h7, 1'b0},
      '{4'h7, 1'b0, 3'h3, 7'h03, 8'h00, 8'h44, 8'h08, 3'h2, 8'h44, 8'h08, 3'h2, 1'b1},
      '{4'h7, 1'b0, 3'h3, 7'h03, 8'h00, 8'h44, 8'hf7, 3'h5, 8'h44, 8'hf7, 3'h5, 1'b0},
      '{4'h8, 1'b0, 3'h5, 7'h03, 8'h00, 8'h44, 8'h00, 3'h7, 8'h44, 8'h00, 3'h7, 1'b1},
      '{4'h8, 1'b0, 3'h5, 7'h03, 8'h00, 8'h44, 8'h20, 3'h0, 8'h44, 8'h20, 3'h0, 1'b0},
      '{4'hf, 1'b1, 3'h0, 7'h03, 8'hff, 8'h66, 8'h77, 3'h4, 8'h66, 8'h77, 3'h4, 1'b0}
   };

   aex_core uut (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
   );

   initial begin
      forever #4 clk_i = ~clk_i;
   end

   function automatic logic [31:0] mk(logic [3:0] op, logic d, logic [2:0] b, logic [6:0] f,
                                      logic [7:0] k);
      return {8'h00, k, 1'b0, f, b, d, op};
   endfunction : mk

   task automatic final_report;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t check %0d got %h expected %h", $time, n_checks, seen, exp);
      end
   endtask : chk

   // Address and data offered together; each dropped on its own handshake edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 1000);
      brsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 1000) chk(32'h0000_0001, 32'h0000_0000);
      @(posedge clk_i);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 1000);
      rdat = s_axi_rdata;
      rrsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 1000) chk(32'h0000_0002, 32'h0000_0000);
      @(posedge clk_i);
   endtask : rd

   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      final_report();
   end

   initial begin
      repeat (16) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      foreach (rows[i]) begin
         r = rows[i];
         wr(`AEX_OFF_ACC, {24'h00_0000, r.acc0});
         wr(`AEX_OFF_FADDR, {25'h000_0000, r.fa});
         wr(`AEX_OFF_FDATA, {24'h00_0000, r.f0});
         wr(`AEX_OFF_STATUS, {29'h0000_0000, r.fl0});
         wr(`AEX_OFF_INSTR, mk(r.op, r.dest, r.bsel, r.fa, r.lit));
         rd(`AEX_OFF_ACC);
         chk(rdat & 32'h0000_00ff, {24'h00_0000, r.acc_e});
         rd(`AEX_OFF_STATUS);
         chk(rdat & 32'h0000_001f, {27'h000_0000, 1'b0, r.skip_e, r.fl_e});
         rd(`AEX_OFF_FDATA);
         chk(rdat & 32'h0000_00ff, {24'h00_0000, r.f_e});
         // A pending skip would swallow the next row's instruction
         if (r.skip_e) wr(`AEX_OFF_INSTR, 32'h0000_0000);
      end
      rd(`AEX_OFF_CYCLES);
      cyc0 = rdat;
      wr(`AEX_OFF_ACC, 32'h0000_0010);
      wr(`AEX_OFF_FADDR, 32'h0000_0009);
      wr(`AEX_OFF_FDATA, 32'h0000_0080);
      wr(`AEX_OFF_INSTR, mk(`AEX_OP_SKIP_SET, 1'b0, 3'h7, 7'h09, 8'h00));
      wr(`AEX_OFF_INSTR, mk(`AEX_OP_ADD_LIT, 1'b0, 3'h0, 7'h00, 8'h05));
      rd(`AEX_OFF_ACC);
      chk(rdat, 32'h0000_0010);
      rd(`AEX_OFF_CYCLES);
      chk(rdat, cyc0 + 32'h0000_0002);
      wr(`AEX_OFF_INSTR, mk(`AEX_OP_ADD_LIT, 1'b0, 3'h0, 7'h00, 8'h05));
      rd(`AEX_OFF_ACC);
      chk(rdat, 32'h0000_0015);
      wr(`AEX_OFF_INSTR, mk(`AEX_OP_SKIP_CLR, 1'b0, 3'h7, 7'h09, 8'h00));
      wr(`AEX_OFF_INSTR, mk(`AEX_OP_ADD_LIT, 1'b0, 3'h0, 7'h00, 8'h01));
      rd(`AEX_OFF_ACC);
      chk(rdat, 32'h0000_0016);
      wr(`AEX_OFF_INSTR, mk(`AEX_OP_SKIP_SET, 1'b0, 3'h0, 7'h09, 8'h00));
      wr(`AEX_OFF_INSTR, mk(`AEX_OP_ADD_LIT, 1'b0, 3'h0, 7'h00, 8'h01));
      rd(`AEX_OFF_ACC);
      chk(rdat, 32'h0000_0017);
      rd(`AEX_OFF_CYCLES);
      chk(rdat, cyc0 + 32'h0000_0007);
      // Lane 0 masked off: the accumulator must keep its value
      s_axi_wstrb <= 4'h0;
      wr(`AEX_OFF_ACC, 32'h0000_00aa);
      s_axi_wstrb <= 4'hf;
      chk({30'h0000_0000, brsp}, {30'h0000_0000, `AEX_RESP_OKAY});
      rd(`AEX_OFF_ACC);
      chk(rdat, 32'h0000_0017);
      chk({30'h0000_0000, rrsp}, {30'h0000_0000, `AEX_RESP_OKAY});
      wr(8'h18, 32'h0000_00aa);
      chk({30'h0000_0000, brsp}, {30'h0000_0000, `AEX_RESP_SLVERR});
      rd(8'h18);
      chk(rdat, 32'h0000_0000);
      chk({30'h0000_0000, rrsp}, {30'h0000_0000, `AEX_RESP_SLVERR});
      sys_rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      rd(`AEX_OFF_ACC);
      chk(rdat, 32'h0000_0000);
      rd(`AEX_OFF_STATUS);
      chk(rdat, 32'h0000_0000);
      rd(`AEX_OFF_FADDR);
      chk(rdat, 32'h0000_0000);
      rd(`AEX_OFF_CYCLES);
      chk(rdat, `AEX_CYC_RST);
      final_report();
   end
endmodule : tb_add_and_bit_ops_exec
